/* rtl/etc_top.sv */
// Exposure timing and frame trigger control with APB registers
//
// What this block does
// - Exposure equals multiplier times time base
// - Multiplier accepted only from 1 to 4095
// - Standard base resets 20 us, 1 us steps
// - Alternate base resets 31 us, 31 us steps
// - Absolute exposure register in whole microseconds
// - Absolute write recomputes the stored multiplier
// - Unreachable absolute value snaps to nearest
// - Multiplier or base change updates absolute readback
// - Backward-compatible mode active after reset
// - Legacy: no acquisition trigger, frame trigger renamed
// - Both triggers off: free run, internal triggers
// - Internal triggers paced by frame period setting
// - Rate disabled: frames at highest allowed rate
// - Frame trigger on: one exposure per trigger
// - Rising edge on line one is trigger
`include "etc_consts.svh"
module etc_top #(
  parameter bit ALT_SENSOR = 1'b0,
  parameter int READOUT_CYCLES = `ETC_READOUT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trig_line_i,
  output logic exposing_o,
  output logic frame_start_o,
  output logic trig_wait_o,
  output logic acq_active_o
);
  // ---------------------------------------------
  // Constants
  // ---------------------------------------------
  localparam int STEP_US = ALT_SENSOR ? `ETC_STEP_ALT_US
                                      : `ETC_STEP_STD_US;
  localparam int BASE_US = ALT_SENSOR ? `ETC_BASE_ALT_US
                                      : `ETC_BASE_STD_US;
  localparam logic [14:0] BASE_RST = 15'(BASE_US / STEP_US);
  localparam int US_CYC = `ETC_US_CYCLES;
  localparam int UW = $clog2(US_CYC);
  localparam int RW = $clog2(READOUT_CYCLES + 1);

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  etc_exp_if ex ();
  logic [4:0] ctrl;
  etc_pkg::etc_mult_t mult;
  logic [14:0] base_steps;
  etc_pkg::etc_base_t base_us;
  logic [31:0] abs_us;
  logic [23:0] period;
  logic setup;
  logic access;
  logic abs_wr;
  logic wr_en;
  logic div_pend;
  etc_pkg::etc_mult_t snap_mult;
  logic [31:0] next_prdata;
  logic next_err;
  logic line_s1;
  logic line_s2;
  logic line_s3;
  logic line_rise;
  logic legacy;
  logic acq_trig_eff;
  logic frm_trig_eff;
  logic run;
  logic [UW-1:0] us_cyc;
  logic us_tick;
  logic [23:0] per_cnt;
  logic rate_ok;
  logic frame_go;
  logic [RW-1:0] rd_cnt;
  etc_pkg::etc_state_e state;

  // ---------------------------------------------
  // Exposure timer and absolute-value divider
  // ---------------------------------------------
  etc_exp_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tmr_if(ex.tmr)
  );

  etc_abs_div u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .div_if(ex.div)
  );

  assign ex.mult = mult;
  assign ex.base_us = base_us;
  assign ex.tmr_start = frame_go;
  assign exposing_o = ex.tmr_busy;

  // ---------------------------------------------
  // Derived exposure values
  // ---------------------------------------------
  // Base held in steps so the alternate sensor can only land on multiples of 31 us
  assign base_us = 20'(base_steps) * 20'(STEP_US);
  // Readback always follows the live product, never a stale copy
  assign abs_us = 32'(mult) * 32'(base_us);

  // Round to nearest: add half a base before dividing
  assign ex.div_num = {1'b0, pwdata_i} + {14'h0000, base_us[19:1]};
  assign ex.div_den = base_us;

  // Quotients outside the legal range clamp to the nearest end
  always_comb begin
    if (ex.div_quo == 33'h000000000) begin
      snap_mult = `ETC_MULT_MIN;
    end else if (ex.div_quo > 33'(`ETC_MULT_MAX)) begin
      snap_mult = `ETC_MULT_MAX;
    end else begin
      snap_mult = ex.div_quo[11:0];
    end
  end

  // ---------------------------------------------
  // APB slave
  // ---------------------------------------------
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign abs_wr = access & pwrite_i & (paddr_i == `ETC_OFS_ABS);
  // Absolute writes wait for the divider, so readback is already snapped
  assign pready_o = ~abs_wr | ex.div_done;
  assign wr_en = access & pwrite_i & pready_o;
  assign ex.div_start = abs_wr & ~div_pend;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_pend <= 1'b0;
    end else if (ex.div_done) begin
      div_pend <= 1'b0;
    end else if (ex.div_start) begin
      div_pend <= 1'b1;
    end
  end

  // Read data sampled in setup, so reads finish with no wait state
  always_comb begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr_i)
      `ETC_OFS_CTRL: next_prdata = {27'h0000000, ctrl};
      `ETC_OFS_MULT: next_prdata = {20'h00000, mult};
      `ETC_OFS_BASE: next_prdata = {17'h00000, base_steps};
      `ETC_OFS_BASE_US: next_prdata = {12'h000, base_us};
      `ETC_OFS_ABS: next_prdata = abs_us;
      `ETC_OFS_PERIOD: next_prdata = {8'h00, period};
      `ETC_OFS_STATUS: begin
        next_prdata = {25'h0000000, state, div_pend,
                       acq_active_o, trig_wait_o, ex.tmr_busy};
      end
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h00000000 : next_prdata;
      pslverr_o <= next_err;
    end
  end

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= `ETC_CTRL_RST;
    end else if (wr_en && paddr_i == `ETC_OFS_CTRL) begin
      ctrl <= pwdata_i[4:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mult <= `ETC_MULT_RST;
    end else if (abs_wr && ex.div_done) begin
      mult <= snap_mult;
    end else if (wr_en && paddr_i == `ETC_OFS_MULT) begin
      if (pwdata_i >= 32'(`ETC_MULT_MIN) &&
          pwdata_i <= 32'(`ETC_MULT_MAX)) begin
        mult <= pwdata_i[11:0];
      end
    end
  end

  // Zero steps would make a zero-length base; such writes are dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      base_steps <= BASE_RST;
    end else if (wr_en && paddr_i == `ETC_OFS_BASE) begin
      if (pwdata_i[31:15] == 17'h00000 &&
          pwdata_i[14:0] != 15'h0000) begin
        base_steps <= pwdata_i[14:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      period <= `ETC_PERIOD_RST;
    end else if (wr_en && paddr_i == `ETC_OFS_PERIOD) begin
      period <= pwdata_i[23:0];
    end
  end

  // ---------------------------------------------
  // Mode decode
  // ---------------------------------------------
  assign legacy = ctrl[`ETC_CTRL_LEGACY];
  assign run = ctrl[`ETC_CTRL_RUN];
  // Legacy: the acquisition bit drives the per-frame trigger instead
  assign acq_trig_eff = ~legacy & ctrl[`ETC_CTRL_ACQ_TRIG];
  assign frm_trig_eff = legacy ? ctrl[`ETC_CTRL_ACQ_TRIG]
                               : ctrl[`ETC_CTRL_FRM_TRIG];

  // ---------------------------------------------
  // Trigger line synchroniser and edge detect
  // ---------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
      line_s3 <= 1'b0;
    end else begin
      line_s1 <= trig_line_i;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
    end
  end

  assign line_rise = line_s2 & ~line_s3;

  // ---------------------------------------------
  // Frame pacing
  // ---------------------------------------------
  // Free-running microsecond tick; pacing may jitter by one microsecond
  assign us_tick = us_cyc == UW'(US_CYC - 1);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      us_cyc <= '0;
    end else begin
      us_cyc <= us_tick ? '0 : us_cyc + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      per_cnt <= '0;
    end else if (frame_go) begin
      per_cnt <= '0;
    end else if (us_tick && per_cnt != 24'hffffff) begin
      per_cnt <= per_cnt + 24'h000001;
    end
  end

  // Exposure and readout still bound the rate when the period is short
  assign rate_ok = ~ctrl[`ETC_CTRL_RATE_EN] |
                   (per_cnt >= period);

  always_comb begin
    frame_go = 1'b0;
    if (state == etc_pkg::ST_WAIT_FRM && run) begin
      if (frm_trig_eff) begin
        frame_go = line_rise;
      end else begin
        frame_go = rate_ok;
      end
    end
  end

  // ---------------------------------------------
  // Acquisition sequencer
  // ---------------------------------------------
  // Edges during exposure or readout are ignored, not queued
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= etc_pkg::ST_IDLE;
    end else begin
      case (state)
        etc_pkg::ST_IDLE: begin
          if (run) begin
            state <= acq_trig_eff ? etc_pkg::ST_WAIT_ACQ
                                  : etc_pkg::ST_WAIT_FRM;
          end
        end
        etc_pkg::ST_WAIT_ACQ: begin
          if (!run) begin
            state <= etc_pkg::ST_IDLE;
          end else if (line_rise) begin
            state <= etc_pkg::ST_WAIT_FRM;
          end
        end
        etc_pkg::ST_WAIT_FRM: begin
          if (!run) begin
            state <= etc_pkg::ST_IDLE;
          end else if (frame_go) begin
            state <= etc_pkg::ST_EXPOSE;
          end
        end
        etc_pkg::ST_EXPOSE: begin
          if (ex.tmr_done) begin
            state <= etc_pkg::ST_READOUT;
          end
        end
        etc_pkg::ST_READOUT: begin
          if (rd_cnt == RW'(READOUT_CYCLES - 1)) begin
            state <= run ? etc_pkg::ST_WAIT_FRM
                         : etc_pkg::ST_IDLE;
          end
        end
        default: state <= etc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_cnt <= '0;
    end else if (state == etc_pkg::ST_READOUT) begin
      rd_cnt <= rd_cnt + 1'b1;
    end else begin
      rd_cnt <= '0;
    end
  end

  // ---------------------------------------------
  // Status outputs
  // ---------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      frame_start_o <= 1'b0;
      trig_wait_o <= 1'b0;
      acq_active_o <= 1'b0;
    end else begin
      frame_start_o <= frame_go;
      trig_wait_o <= (state == etc_pkg::ST_WAIT_FRM && frm_trig_eff) ||
                     state == etc_pkg::ST_WAIT_ACQ;
      acq_active_o <= state != etc_pkg::ST_IDLE &&
                      state != etc_pkg::ST_WAIT_ACQ;
    end
  end
endmodule // etc_top

/* rtl/etc_consts.svh */
// Offsets, field positions, reset values and timing counts
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define ETC_OFS_CTRL 12'h000
`define ETC_OFS_MULT 12'h004
`define ETC_OFS_BASE 12'h008
`define ETC_OFS_BASE_US 12'h00c
`define ETC_OFS_ABS 12'h010
`define ETC_OFS_PERIOD 12'h014
`define ETC_OFS_STATUS 12'h018
// ---------------------------------------------
// Control fields and reset values
// ---------------------------------------------
`define ETC_CTRL_LEGACY 0
`define ETC_CTRL_ACQ_TRIG 1
`define ETC_CTRL_FRM_TRIG 2
`define ETC_CTRL_RATE_EN 3
`define ETC_CTRL_RUN 4
`define ETC_CTRL_RST 5'h01
`define ETC_MULT_MIN 12'h001
`define ETC_MULT_MAX 12'hfff
`define ETC_MULT_RST 12'h064
`define ETC_PERIOD_RST 24'h008235
// ---------------------------------------------
// Time base and timing, microseconds and ns
// ---------------------------------------------
`define ETC_BASE_STD_US 20
`define ETC_STEP_STD_US 1
`define ETC_BASE_ALT_US 31
`define ETC_STEP_ALT_US 31
`define ETC_CLK_NS 10
`define ETC_US_NS 1000
`define ETC_US_CYCLES ((`ETC_US_NS + `ETC_CLK_NS - 1) / `ETC_CLK_NS)
`define ETC_READOUT_CYCLES 16
`endif

/* rtl/etc_pkg.sv */
// Types shared by the exposure and trigger control block
package etc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_ACQ = 3'b001,
    ST_WAIT_FRM = 3'b010,
    ST_EXPOSE = 3'b011,
    ST_READOUT = 3'b100
  } etc_state_e;
  typedef logic [11:0] etc_mult_t;
  typedef logic [19:0] etc_base_t;
endpackage

/* rtl/etc_exp_if.sv */
// Carrier between controller, exposure timer and divider
interface etc_exp_if;
  logic tmr_start;
  etc_pkg::etc_mult_t mult;
  etc_pkg::etc_base_t base_us;
  logic tmr_busy;
  logic tmr_done;
  logic div_start;
  logic [32:0] div_num;
  etc_pkg::etc_base_t div_den;
  logic div_done;
  logic [32:0] div_quo;
  modport ctrl (
    output tmr_start, mult, base_us, div_start, div_num, div_den,
    input tmr_busy, tmr_done, div_done, div_quo
  );
  modport tmr (
    input tmr_start, mult, base_us,
    output tmr_busy, tmr_done
  );
  modport div (
    input div_start, div_num, div_den,
    output div_done, div_quo
  );
endinterface

/* rtl/etc_exp_timer.sv */
// Exposure timer: multiplier count of base-length intervals
`include "etc_consts.svh"
module etc_exp_timer (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  etc_exp_if.tmr tmr_if
);
  localparam int US_CYC = `ETC_US_CYCLES;
  localparam int CW = $clog2(US_CYC);
  logic [CW-1:0] cyc_cnt;
  etc_pkg::etc_base_t us_cnt;
  etc_pkg::etc_base_t base_l;
  etc_pkg::etc_mult_t mult_cnt;
  etc_pkg::etc_mult_t mult_l;
  logic busy;
  logic done;
  logic cyc_end;
  logic us_end;
  assign cyc_end = cyc_cnt == CW'(US_CYC - 1);
  assign us_end = us_cnt == base_l - 20'h00001;
  assign tmr_if.tmr_busy = busy;
  assign tmr_if.tmr_done = done;
  // Settings latched at start so host writes cannot bend a running exposure
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      done <= 1'b0;
      cyc_cnt <= '0;
      us_cnt <= '0;
      mult_cnt <= '0;
      base_l <= '0;
      mult_l <= '0;
    end else begin
      done <= 1'b0;
      if (tmr_if.tmr_start && !busy) begin
        busy <= 1'b1;
        base_l <= tmr_if.base_us;
        mult_l <= tmr_if.mult;
        cyc_cnt <= '0;
        us_cnt <= '0;
        mult_cnt <= '0;
      end else if (busy) begin
        cyc_cnt <= cyc_end ? '0 : cyc_cnt + 1'b1;
        if (cyc_end) begin
          us_cnt <= us_end ? '0 : us_cnt + 20'h00001;
        end
        if (cyc_end && us_end) begin
          mult_cnt <= mult_cnt + 12'h001;
          if (mult_cnt == mult_l - 12'h001) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // etc_exp_timer

/* rtl/etc_abs_div.sv */
// Restoring divider turning microseconds into a multiplier
module etc_abs_div (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  etc_exp_if.div div_if
);
  localparam int NW = 33;
  localparam int DW = 20;
  logic [5:0] cnt;
  logic busy;
  logic done;
  logic [DW-1:0] rem;
  logic [DW-1:0] den;
  logic [NW-1:0] quo;
  logic [DW:0] shl;
  logic fits;
  assign shl = {rem, quo[NW-1]};
  assign fits = shl >= {1'b0, den};
  assign div_if.div_done = done;
  assign div_if.div_quo = quo;
  // One quotient bit per clock; small area beats a fast divide here
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
      rem <= '0;
      den <= '0;
      quo <= '0;
    end else begin
      done <= 1'b0;
      if (div_if.div_start && !busy) begin
        busy <= 1'b1;
        quo <= div_if.div_num;
        den <= div_if.div_den;
        rem <= '0;
        cnt <= '0;
      end else if (busy) begin
        rem <= fits ? DW'(shl - {1'b0, den}) : DW'(shl);
        quo <= {quo[NW-2:0], fits};
        cnt <= cnt + 6'h01;
        if (cnt == 6'(NW - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // etc_abs_div

/* tb/etc_trig_src.sv */
// Trigger sensor model driving input line 1
module etc_trig_src (
  input wire logic core_clk_i,
  input wire logic fire_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold = 3'h0;
  logic line = 1'b0;
  assign line_o = line;
  // One rising edge per request; high 3, then low at least 4 cycles
  always @(posedge core_clk_i) begin
    if (fire_i && hold == 3'h0) begin
      line <= 1'b1;
      hold <= 3'h7;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
      if (hold == 3'h5) begin
        line <= 1'b0;
      end
    end
  end
endmodule // etc_trig_src

/* tb/etc_top_asserts.sv */
// Port checker for the exposure and trigger control block
`include "etc_consts.svh"
module etc_top_asserts #(
  parameter bit ALT_SENSOR = 1'b0,
  parameter int READOUT_CYCLES = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic trig_line_i,
  input wire logic exposing_o,
  input wire logic frame_start_o,
  input wire logic trig_wait_o,
  input wire logic acq_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------
  // Shadow of the exposure settings
  // ---------------------------------
  logic wr_ok;
  logic abs_acc;
  logic [14:0] base;
  logic [11:0] mult;
  logic [63:0] base_us, quo, need, cnt;
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  assign abs_acc = psel_i && penable_i && pwrite_i && paddr_i == `ETC_OFS_ABS;
  assign base_us = ALT_SENSOR ? 64'(base) * 64'd31 : 64'(base);
  // Nearest, ties up; base is never zero so no divide trap
  assign quo = (64'(pwdata_i) + base_us / 64'd2) / base_us;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      base <= ALT_SENSOR ? 15'h0001 : 15'h0014;
    end else if (wr_ok && paddr_i == `ETC_OFS_BASE && pwdata_i != 32'h0
                 && pwdata_i <= 32'h7fff) begin
      base <= pwdata_i[14:0];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mult <= `ETC_MULT_RST;
    end else if (wr_ok && paddr_i == `ETC_OFS_MULT && pwdata_i != 32'h0
                 && pwdata_i <= 32'hfff) begin
      mult <= pwdata_i[11:0];
    end else if (wr_ok && paddr_i == `ETC_OFS_ABS) begin
      mult <= quo == 64'h0 ? 12'h001 : quo > 64'hfff ? 12'hfff : quo[11:0];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt <= 64'h0;
      need <= 64'h0;
    end else begin
      cnt <= exposing_o ? cnt + 64'h1 : 64'h0;
      if ($rose(exposing_o)) begin
        need <= 64'(mult) * base_us * 64'd100;
      end
    end
  end
  exp_len_a: assert property ($fell(exposing_o)
    |-> cnt == need)
    else $error("exposure length is not multiplier times base");
  frame_pulse_a: assert property (frame_start_o
    |=> !frame_start_o)
    else $error("frame start pulse wider than one cycle");
  start_pair_a: assert property ($rose(exposing_o)
    |-> frame_start_o)
    else $error("exposure began without frame start");
  // Wait flag is registered, so it overlaps the first exposure cycle
  no_wait_a: assert property (exposing_o && !frame_start_o
    |-> !trig_wait_o && acq_active_o)
    else $error("exposing while waiting for a trigger");
  trig_lat_a: assert property (trig_wait_o && acq_active_o
    && $rose(trig_line_i) |-> ##[3:4] $rose(exposing_o))
    else $error("line edge did not start an exposure");
  readout_gap_a: assert property ($fell(exposing_o)
    |-> !exposing_o [*2])
    else $error("exposure restarted during readout");
  abs_wait_a: assert property ($rose(abs_acc)
    |-> !pready_o [*8] ##[1:30] pready_o)
    else $error("absolute write answered at the wrong time");
  bus_ready_a: assert property (psel_i && penable_i && !abs_acc
    |-> pready_o)
    else $error("register access stalled");
  cover property (wr_ok && paddr_i == `ETC_OFS_ABS);
  cover property (trig_wait_o && $rose(exposing_o));
  cover property (!trig_wait_o && frame_start_o);
endmodule // etc_top_asserts

bind etc_top etc_top_asserts #(
  .ALT_SENSOR(ALT_SENSOR),
  .READOUT_CYCLES(READOUT_CYCLES)
) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .trig_line_i(trig_line_i),
  .exposing_o(exposing_o), .frame_start_o(frame_start_o),
  .trig_wait_o(trig_wait_o), .acq_active_o(acq_active_o)
);

/* tb/tb.sv */
// Self-checking bench for the exposure and trigger control block
`include "etc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fire = 1'b0;
  logic use_alt = 1'b0;
  logic [31:0] prdata, prdata_alt, q;
  logic pready, pslverr, se, trig_line, exposing, frame_start, trig_wait;
  logic acq_active;
  int err_total = 0;
  int num_checks = 0;
  int frames = 0;
  int exp_cyc = 0;
  logic [31:0] mv [4] = '{32'h0, 32'h1000, 32'hfff, 32'h1};
  logic [31:0] me [4] = '{32'h64, 32'h64, 32'hfff, 32'h1};
  logic [31:0] av [5] = '{32'h46, 32'h4a, 32'h49, 32'h0, 32'h186a0};
  logic [31:0] am [5] = '{32'ha, 32'hb, 32'ha, 32'h1, 32'hfff};
  logic [31:0] ar [5] = '{32'h46, 32'h4d, 32'h46, 32'h7, 32'h6ff9};
  logic [31:0] cv [2] = '{32'h13, 32'h14};
  logic [31:0] fv [2] = '{32'h10, 32'h15};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (frame_start === 1'b1) frames++;
    if (exposing === 1'b1) exp_cyc++;
  end
  // Short readout keeps frame loops brief
  etc_top #(.ALT_SENSOR(1'b0), .READOUT_CYCLES(2)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .trig_line_i(trig_line), .exposing_o(exposing),
    .frame_start_o(frame_start), .trig_wait_o(trig_wait),
    .acq_active_o(acq_active));
  // Alternate variant shares the bus; only its read data is watched
  etc_top #(.ALT_SENSOR(1'b1), .READOUT_CYCLES(2)) dut_alt (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_alt), .pready_o(), .pslverr_o(),
    .trig_line_i(trig_line), .exposing_o(), .frame_start_o(),
    .trig_wait_o(), .acq_active_o());
  etc_trig_src u_src (.core_clk_i(clk), .fire_i(fire), .line_o(trig_line));
  // ---------------------------------
  // Bus tasks and comparison
  // ---------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Ready, read data and error all taken at the same rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      results();
    end
    q = use_alt ? prdata_alt : prdata;
    se = pslverr;
    // Released at once; a held access would restart the divider
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic fire_line();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // ---------------------------------
  // Test sequence
  // ---------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ETC_OFS_CTRL, 32'h1, "ctrl");
    rd(`ETC_OFS_MULT, 32'h64, "mult");
    rd(`ETC_OFS_BASE_US, 32'h14, "base_us");
    rd(`ETC_OFS_ABS, 32'h7d0, "abs");
    rd(`ETC_OFS_PERIOD, 32'h8235, "period");
    $display("test reset finished");
    use_alt = 1'b1;
    rd(`ETC_OFS_BASE_US, 32'h1f, "alt base_us");
    rd(`ETC_OFS_ABS, 32'hc1c, "alt abs");
    wr(`ETC_OFS_BASE, 32'h2);
    rd(`ETC_OFS_BASE_US, 32'h3e, "alt base_us");
    rd(`ETC_OFS_ABS, 32'h1838, "alt abs");
    use_alt = 1'b0;
    $display("test alternate finished");
    foreach (mv[i]) begin
      wr(`ETC_OFS_MULT, mv[i]);
      rd(`ETC_OFS_MULT, me[i], "mult");
    end
    // Shared bus: the base of 2 steps written above landed here too
    rd(`ETC_OFS_ABS, 32'h2, "abs");
    $display("test multiplier finished");
    wr(`ETC_OFS_BASE, 32'h0);
    rd(`ETC_OFS_BASE_US, 32'h2, "base_us");
    wr(`ETC_OFS_BASE, 32'h7);
    rd(`ETC_OFS_ABS, 32'h7, "abs");
    foreach (av[i]) begin
      wr(`ETC_OFS_ABS, av[i]);
      rd(`ETC_OFS_MULT, am[i], "abs mult");
      rd(`ETC_OFS_ABS, ar[i], "abs back");
    end
    $display("test absolute finished");
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, se});
    $display("test unmapped finished");
    wr(`ETC_OFS_MULT, 32'h1);
    wr(`ETC_OFS_BASE, 32'h1);
    foreach (cv[i]) begin
      wr(`ETC_OFS_CTRL, cv[i]);
      repeat (4) @(posedge clk);
      frames = 0;
      exp_cyc = 0;
      chk("trig_wait", 32'h1, {31'h0, trig_wait});
      chk("acq_active", 32'h1, {31'h0, acq_active});
      fire_line();
      repeat (30) @(posedge clk);
      // Second edge lands mid-exposure and must be dropped
      fire_line();
      repeat (200) @(posedge clk);
      chk("frames", 32'h1, 32'(frames));
      chk("exp_len", 32'h64, 32'(exp_cyc));
    end
    $display("test trigger finished");
    // Standard mode with the acquisition trigger: one edge arms free run
    wr(`ETC_OFS_CTRL, 32'h2);
    wr(`ETC_OFS_CTRL, 32'h12);
    repeat (2) @(posedge clk);
    rd(`ETC_OFS_STATUS, 32'h12, "status");
    frames = 0;
    fire_line();
    repeat (300) @(posedge clk);
    chk("armed frames", 32'h1, {31'h0, frames >= 2});
    $display("test acquisition arm finished");
    foreach (fv[i]) begin
      wr(`ETC_OFS_CTRL, fv[i]);
      frames = 0;
      repeat (400) @(posedge clk);
      chk("free frames", 32'h1, {31'h0, frames >= 3});
    end
    $display("test free run finished");
    wr(`ETC_OFS_PERIOD, 32'h5);
    wr(`ETC_OFS_CTRL, 32'h18);
    frames = 0;
    repeat (2000) @(posedge clk);
    chk("paced", 32'h1, {31'h0, frames >= 3 && frames <= 5});
    $display("test paced finished");
    results();
  end
endmodule // tb
